// ---- logic/smc_pkg.sv ----
// Package: constants and carriers for the serial modem control block
package smc_pkg;

    // Register map (word indices on the plain register port)
    localparam logic [3:0] ADDR_CFG_A = 4'h0;
    localparam logic [3:0] ADDR_CFG_B = 4'h1;
    localparam logic [3:0] ADDR_MASK = 4'h2;
    localparam logic [3:0] ADDR_STATUS = 4'h3;
    localparam logic [3:0] ADDR_STATE = 4'h4;

    // channel_config_a fields
    localparam int CFGA_ENGINE_LSB = 0;
    localparam int CFGA_BUS_CFG = 2;
    localparam int CFGA_CLK_MODE_LSB = 4;
    localparam int CFGA_ASYNC_CHAR = 8;
    // channel_config_b fields
    localparam int CFGB_RTS_FN_LSB = 0;
    localparam int CFGB_RTS_SW = 2;
    localparam int CFGB_CD_AUTO = 3;
    localparam int CFGB_LOOP = 4;
    localparam int CFGB_SUBMODE_LSB = 5;
    localparam int CFGB_ADDR_WIDTH = 7;
    localparam int CFGB_PTP_LSB = 8;
    localparam int CFGB_SYNC_CNT = 10;
    // Status bits
    localparam int ST_CTS_CHANGE = 0;
    localparam int ST_XMIT_REPEAT = 1;
    localparam int ST_ALL_SENT = 2;

    localparam logic [31:0] CFG_A_RST = 32'h0000_0000;
    localparam logic [31:0] CFG_B_RST = 32'h0000_0000;
    localparam logic [31:0] MASK_RST = 32'h0000_0007;
    localparam logic [3:0] CHAR_BITS = 4'h8;

    typedef enum logic [1:0] {
        ENG_FRAMED = 2'b00,
        ENG_BYTESYNC = 2'b10,
        ENG_ASYNC = 2'b11
    } smc_engine_t;

    typedef enum logic [1:0] {
        RTSF_STD = 2'b00,
        RTSF_BUS_TX = 2'b01,
        RTSF_OFF = 2'b10,
        RTSF_RX = 2'b11
    } smc_rts_fn_t;

    typedef enum logic [4:0] {
        TX_IDLE = 5'b00001,
        TX_WAIT = 5'b00010,
        TX_SEND = 5'b00100,
        TX_DRAIN = 5'b01000,
        TX_HOLD = 5'b10000
    } smc_tx_state_t;

    typedef enum logic [2:0] {
        SUB_AUTO = 3'h0,
        SUB_NONAUTO = 3'h1,
        SUB_ADDR1 = 3'h2,
        SUB_ADDR0 = 3'h3,
        SUB_XTRANS = 3'h4
    } smc_submode_t;

    typedef struct packed {
        logic cts_n;
        logic cd;
        logic rxd;
    } smc_pins_in_t;

    typedef struct packed {
        logic [3:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } smc_bus_req_t;

endpackage

// ---- logic/smc_modem_ctrl.sv ----
// Modem handshake, loopback and protocol mode selection for one serial channel
// Operation
// - A pending transmit request drives request-to-send low.
// - Software may drive request-to-send directly.
// - Sending starts only after clear-to-send grants permission.
// - Framed and byte-sync engines abort frame and send idle on lost permission.
// - Aborted frame retransmits after permission returns if its start is still buffered.
// - Lost permission after buffer release resets transmitter, drops request, raises repeat.
// - Async engine finishes current character then idles on lost permission.
// - Async engine resumes with next character after permission returns.
// - Every clear-to-send transition raises a status; its mask bit only gates the interrupt.
// - Alternative request-to-send functions only in bus config, clock mode 0/1, framed.
// - Function 11 drives request-to-send low during frame reception.
// - Function 10 holds request-to-send high constantly.
// - Carrier auto start works in clock modes 0,2,3,6,7, not 1.
// - With auto start, receiver runs while carrier detect is high.
// - Carrier loss still completes the byte being received.
// - Loop test routes transmit data to the receive input.
// - Transmit pin keeps carrying data during loop test.
// - Loop test not offered in clock mode 4.
// - Two-bit field selects framed, async or byte-sync engine and sub-variants.
// - Framed sub-mode field with address-width bit decodes to five modes.
// - Point-to-point framing field decodes to disabled, async, bit-sync, octet-sync.
`timescale 1ns/1ps

module smc_modem_ctrl (
    input wire logic core_clk_i, // 100 MHz clock
    input wire logic srst_i, // Sync reset, active high
    input wire smc_pkg::smc_bus_req_t bus_i, // Register port request
    output logic [31:0] rdata_o, // Read data, cycle after read
    input wire smc_pkg::smc_pins_in_t pins_i, // Async modem pins
    input wire logic tx_req_i, // Transmitter has data pending
    input wire logic tx_bit_i, // Serial data from shifter
    input wire logic tx_char_end_i, // Character/bit boundary pulse
    input wire logic tx_frame_end_i, // Last bit of frame sent
    input wire logic tx_start_held_i, // Frame start still in buffer
    input wire logic tx_pool_released_i, // Shadow data sent, pool freed
    input wire logic rx_frame_active_i, // Receiver inside a frame
    input wire logic rx_byte_end_i, // Received byte complete pulse
    output logic rts_n_o, // Request to send, active low
    output logic txd_o, // Serial data pin
    output logic rx_data_o, // Serial data to receiver
    output logic rx_enable_o, // Receiver enabled
    output logic tx_enable_o, // Shifter may send
    output logic tx_restart_o, // Retransmit frame pulse
    output logic tx_flush_o, // Reset transmitter and buffer pulse
    output logic [1:0] engine_o, // Selected protocol engine
    output logic [2:0] submode_o, // Decoded framed sub-mode
    output logic [1:0] ptp_mode_o, // Point-to-point framing
    output logic irq_pending_o // Any unmasked status set
);

    typedef struct packed {
        logic [2:0] cts_sync;
        logic [2:0] cd_sync;
        logic [2:0] rxd_sync;
        logic cts_ok;
        logic cd_hi;
        logic [31:0] cfg_a;
        logic [31:0] cfg_b;
        logic [2:0] mask;
        logic [2:0] status;
        smc_pkg::smc_tx_state_t tx_st;
        logic rx_on;
        logic rx_draining;
        logic [31:0] rdata;
        logic rts_n;
        logic txd;
        logic rx_data;
        logic tx_en;
        logic restart;
        logic flush;
        logic [1:0] engine;
        logic [2:0] submode;
        logic [1:0] ptp;
        logic irq;
    } smc_state_t;

    smc_state_t s_q, s_d;

    logic [1:0] eng;
    logic [3:0] clk_mode;
    logic bus_cfg;
    logic [1:0] rts_fn;
    logic alt_rts_ok;
    logic cd_auto_ok;
    logic loop_ok;
    logic cts_ok_new;
    logic cd_new;
    logic cts_edge;
    logic [1:0] sub_raw;
    logic [2:0] ev;
    logic [1:0][2:0] ctl_stages;
    logic [1:0] ctl_prev;
    logic [1:0] ctl_lvl;

    // Control pins: level moves only once stages two and three agree
    assign ctl_stages = {s_q.cts_sync, s_q.cd_sync};
    assign ctl_prev = {~s_q.cts_ok, s_q.cd_hi};
    for (genvar p = 0; p < 2; p++) begin : g_ctl_filter
        assign ctl_lvl[p] = (ctl_stages[p][1] == ctl_stages[p][2]) ? ctl_stages[p][2] : ctl_prev[p];
    end

    always_comb begin
        s_d = s_q;
        eng = s_q.cfg_a[smc_pkg::CFGA_ENGINE_LSB +: 2];
        clk_mode = s_q.cfg_a[smc_pkg::CFGA_CLK_MODE_LSB +: 4];
        bus_cfg = s_q.cfg_a[smc_pkg::CFGA_BUS_CFG];
        rts_fn = s_q.cfg_b[smc_pkg::CFGB_RTS_FN_LSB +: 2];
        sub_raw = s_q.cfg_b[smc_pkg::CFGB_SUBMODE_LSB +: 2];
        ev = 3'h0;
        s_d.restart = 1'b0;
        s_d.flush = 1'b0;

        // Three-stage sync; a change counts when stages two and three agree
        s_d.cts_sync = {s_q.cts_sync[1:0], pins_i.cts_n};
        s_d.cd_sync = {s_q.cd_sync[1:0], pins_i.cd};
        s_d.rxd_sync = {s_q.rxd_sync[1:0], pins_i.rxd};
        cts_ok_new = ~ctl_lvl[1];
        cd_new = ctl_lvl[0];
        cts_edge = cts_ok_new != s_q.cts_ok;
        s_d.cts_ok = cts_ok_new;
        s_d.cd_hi = cd_new;
        ev[smc_pkg::ST_CTS_CHANGE] = cts_edge;

        // Mode decode
        s_d.engine = eng;
        s_d.ptp = s_q.cfg_b[smc_pkg::CFGB_PTP_LSB +: 2];
        unique case (sub_raw)
            2'b00: s_d.submode = smc_pkg::SUB_AUTO;
            2'b01: s_d.submode = smc_pkg::SUB_NONAUTO;
            2'b10: s_d.submode = s_q.cfg_b[smc_pkg::CFGB_ADDR_WIDTH] ? smc_pkg::SUB_ADDR1 : smc_pkg::SUB_ADDR0;
            2'b11: s_d.submode = smc_pkg::SUB_XTRANS;
        endcase
        alt_rts_ok = bus_cfg && (clk_mode <= 4'h1) && (eng == smc_pkg::ENG_FRAMED);
        cd_auto_ok = (clk_mode != 4'h1) && (clk_mode != 4'h4) && (clk_mode != 4'h5);
        loop_ok = s_q.cfg_b[smc_pkg::CFGB_LOOP] && (clk_mode != 4'h4);

        // Transmit handshake
        unique case (s_q.tx_st)
            smc_pkg::TX_IDLE: begin
                if (tx_req_i) begin
                    s_d.tx_st = smc_pkg::TX_WAIT;
                end
            end
            smc_pkg::TX_WAIT: begin
                if (s_q.cts_ok) begin
                    s_d.tx_st = smc_pkg::TX_SEND;
                end
            end
            smc_pkg::TX_SEND: begin
                if (tx_frame_end_i && !tx_req_i) begin
                    s_d.tx_st = smc_pkg::TX_IDLE;
                    ev[smc_pkg::ST_ALL_SENT] = 1'b1;
                end else if (!s_q.cts_ok) begin
                    if (eng == smc_pkg::ENG_ASYNC) begin
                        s_d.tx_st = tx_char_end_i ? smc_pkg::TX_WAIT : smc_pkg::TX_DRAIN;
                    end else if (tx_pool_released_i) begin
                        s_d.tx_st = smc_pkg::TX_IDLE;
                        s_d.flush = 1'b1;
                        ev[smc_pkg::ST_XMIT_REPEAT] = 1'b1;
                    end else begin
                        s_d.tx_st = smc_pkg::TX_HOLD;
                    end
                end
            end
            smc_pkg::TX_DRAIN: begin
                if (tx_char_end_i) begin
                    s_d.tx_st = smc_pkg::TX_WAIT;
                end
            end
            smc_pkg::TX_HOLD: begin
                if (s_q.cts_ok) begin
                    if (tx_start_held_i) begin
                        s_d.tx_st = smc_pkg::TX_SEND;
                        s_d.restart = 1'b1;
                    end else begin
                        s_d.tx_st = smc_pkg::TX_IDLE;
                        s_d.flush = 1'b1;
                        ev[smc_pkg::ST_XMIT_REPEAT] = 1'b1;
                    end
                end
            end
        endcase
        s_d.tx_en = (s_d.tx_st == smc_pkg::TX_SEND) || (s_d.tx_st == smc_pkg::TX_DRAIN);
        s_d.txd = s_d.tx_en ? tx_bit_i : 1'b1;

        // Request to send
        if (alt_rts_ok && rts_fn == smc_pkg::RTSF_OFF) begin
            s_d.rts_n = 1'b1;
        end else if (alt_rts_ok && rts_fn == smc_pkg::RTSF_RX) begin
            s_d.rts_n = ~rx_frame_active_i;
        end else if (alt_rts_ok && rts_fn == smc_pkg::RTSF_BUS_TX) begin
            s_d.rts_n = ~s_q.tx_en;
        end else begin
            s_d.rts_n = ~((s_d.tx_st != smc_pkg::TX_IDLE) || s_q.cfg_b[smc_pkg::CFGB_RTS_SW]);
        end

        // Receiver control
        if (s_q.cfg_b[smc_pkg::CFGB_CD_AUTO] && cd_auto_ok) begin
            if (s_q.cd_hi) begin
                s_d.rx_on = 1'b1;
                s_d.rx_draining = 1'b0;
            end else if (s_q.rx_on && !s_q.rx_draining) begin
                s_d.rx_draining = 1'b1;
            end else if (s_q.rx_draining && rx_byte_end_i) begin
                s_d.rx_on = 1'b0;
                s_d.rx_draining = 1'b0;
            end
        end else begin
            s_d.rx_on = 1'b1;
            s_d.rx_draining = 1'b0;
        end
        s_d.rx_data = loop_ok ? s_d.txd : s_q.rxd_sync[2];

        // Register port; hardware set wins over software clear
        s_d.rdata = 32'h0000_0000;
        if (bus_i.wr) begin
            unique case (bus_i.addr)
                smc_pkg::ADDR_CFG_A: s_d.cfg_a = bus_i.wdata;
                smc_pkg::ADDR_CFG_B: s_d.cfg_b = bus_i.wdata;
                smc_pkg::ADDR_MASK: s_d.mask = bus_i.wdata[2:0];
                smc_pkg::ADDR_STATUS: s_d.status = s_q.status & ~bus_i.wdata[2:0];
                default: ;
            endcase
        end
        if (bus_i.rd) begin
            unique case (bus_i.addr)
                smc_pkg::ADDR_CFG_A: s_d.rdata = s_q.cfg_a;
                smc_pkg::ADDR_CFG_B: s_d.rdata = s_q.cfg_b;
                smc_pkg::ADDR_MASK: s_d.rdata = {29'h0, s_q.mask};
                smc_pkg::ADDR_STATUS: s_d.rdata = {29'h0, s_q.status};
                smc_pkg::ADDR_STATE: s_d.rdata = {24'h0, s_q.cts_ok, s_q.cd_hi, s_q.rx_on, s_q.tx_st};
                default: s_d.rdata = 32'h0000_0000;
            endcase
        end
        // Status records every event; the mask only gates the summary
        s_d.status = s_d.status | ev;
        s_d.irq = |(s_d.status & ~s_d.mask);
    end

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            s_q <= '0;
            s_q.cts_sync <= 3'h7;
            s_q.rxd_sync <= 3'h7;
            s_q.cfg_a <= smc_pkg::CFG_A_RST;
            s_q.cfg_b <= smc_pkg::CFG_B_RST;
            s_q.mask <= smc_pkg::MASK_RST[2:0];
            s_q.tx_st <= smc_pkg::TX_IDLE;
            s_q.rts_n <= 1'b1;
            s_q.txd <= 1'b1;
            s_q.rx_data <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign rdata_o = s_q.rdata;
    assign rts_n_o = s_q.rts_n;
    assign txd_o = s_q.txd;
    assign rx_data_o = s_q.rx_data;
    assign rx_enable_o = s_q.rx_on;
    assign tx_enable_o = s_q.tx_en;
    assign tx_restart_o = s_q.restart;
    assign tx_flush_o = s_q.flush;
    assign engine_o = s_q.engine;
    assign submode_o = s_q.submode;
    assign ptp_mode_o = s_q.ptp;
    assign irq_pending_o = s_q.irq;

endmodule

// ---- tb/smc_modem_ctrl_asserts.sv ----
// Concurrent checks on the modem control block ports
`timescale 1ns/1ps
module smc_modem_ctrl_chk (
    input wire logic core_clk_i, // Clock
    input wire logic srst_i, // Sync reset
    input wire smc_pkg::smc_bus_req_t bus_i, // Register request
    input wire smc_pkg::smc_pins_in_t pins_i, // Modem pins
    input wire logic tx_req_i, // Tx pending
    input wire logic rts_n_o, // Request to send
    input wire logic txd_o, // Tx pin
    input wire logic rx_data_o, // Rx serial
    input wire logic rx_enable_o, // Rx enabled
    input wire logic tx_enable_o, // Tx enabled
    input wire logic [1:0] engine_o, // Engine
    input wire logic [1:0] ptp_mode_o, // Framing
    input wire logic irq_pending_o // Irq level
);
    logic [31:0] cfg_a_q;
    logic [31:0] cfg_b_q;
    logic [2:0] mask_q;
    wire logic [3:0] mode = cfg_a_q[7:4];
    wire logic alt = cfg_a_q[2] && mode <= 4'h1 && cfg_a_q[1:0] == 2'b00;
    wire logic sw_on = cfg_b_q[2] && !alt;
    wire logic off_on = alt && cfg_b_q[1:0] == 2'b10;
    wire logic loop_on = cfg_b_q[4] && mode != 4'h4;
    wire logic cd_on = cfg_b_q[3] && !(mode inside {4'h1, 4'h4, 4'h5}) && pins_i.cd;
    // Shadow of the configuration words
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            cfg_a_q <= smc_pkg::CFG_A_RST;
            cfg_b_q <= smc_pkg::CFG_B_RST;
            mask_q <= smc_pkg::MASK_RST[2:0];
        end else if (bus_i.wr) begin
            if (bus_i.addr == smc_pkg::ADDR_CFG_A) cfg_a_q <= bus_i.wdata;
            if (bus_i.addr == smc_pkg::ADDR_CFG_B) cfg_b_q <= bus_i.wdata;
            if (bus_i.addr == smc_pkg::ADDR_MASK) mask_q <= bus_i.wdata[2:0];
        end
    end
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (srst_i);
    a_rts_after_reset: assert property ($fell(srst_i) |-> rts_n_o && txd_o)
        else $error("request or data line not idle after reset");
    a_rts_request: assert property ($rose(tx_req_i) && !alt |-> ##2 !rts_n_o)
        else $error("request to send not low two cycles after tx request");
    a_rts_software: assert property (sw_on [*3] |-> !rts_n_o)
        else $error("software request to send not driven low");
    a_rts_disabled: assert property (off_on [*3] |-> rts_n_o)
        else $error("disabled request to send not high");
    a_no_grant_idle: assert property (pins_i.cts_n [*8] ##0 cfg_a_q[1:0] != 2'b11 |-> !tx_enable_o && txd_o)
        else $error("transmitting without clear to send");
    a_loop_route: assert property ((loop_on && txd_o) [*6] |-> rx_data_o)
        else $error("loopback does not carry transmit data");
    a_irq_masked: assert property ((mask_q == 3'b111) [*2] |-> !irq_pending_o)
        else $error("interrupt pending while fully masked");
    a_cd_start: assert property (cd_on [*8] |-> rx_enable_o)
        else $error("carrier did not start receiver");
    a_engine_copy: assert property ($stable(cfg_a_q) |-> engine_o == cfg_a_q[1:0])
        else $error("engine output differs from configuration");
    a_ptp_copy: assert property ($stable(cfg_b_q) |-> ptp_mode_o == cfg_b_q[9:8])
        else $error("framing output differs from configuration");
    c_tx_on: cover property (tx_enable_o);
    c_rx_hold: cover property (rx_enable_o && !pins_i.cd);
    c_loop: cover property (loop_on && !txd_o);
endmodule

bind smc_modem_ctrl smc_modem_ctrl_chk smc_modem_ctrl_chk_inst (.core_clk_i, .srst_i, .bus_i, .pins_i, .tx_req_i,
    .rts_n_o, .txd_o, .rx_data_o, .rx_enable_o, .tx_enable_o, .engine_o, .ptp_mode_o, .irq_pending_o);

// ---- tb/smc_modem_model.sv ----
// Modem side model: grants clear to send, presents carrier and line data
`timescale 1ns/1ps
module smc_modem_model #(
    parameter int GRANT_DLY = 3
) (
    input wire logic core_clk_i, // Clock
    input wire logic rts_n_i, // Request from block
    input wire logic allow_i, // Bench permits a grant
    input wire logic cd_i, // Carrier level
    output wire smc_pkg::smc_pins_in_t pins_o // Modem pins
);
    int wait_q = 0;
    logic pat_q = 1'b0;
    always_ff @(posedge core_clk_i) begin
        pat_q <= !pat_q;
        if (!allow_i || rts_n_i) begin
            wait_q <= 0;
        end else if (wait_q < GRANT_DLY) begin
            wait_q <= wait_q + 1;
        end
    end
    // Grant only after the request stood for the delay
    assign pins_o.cts_n = !(allow_i && wait_q == GRANT_DLY);
    assign pins_o.cd = cd_i;
    // Line data toggles so a missed loopback shows
    assign pins_o.rxd = pat_q;
endmodule

// ---- tb/smc_modem_ctrl_bench.sv ----
// Self-checking bench for the modem control block
`timescale 1ns/1ps
module smc_modem_ctrl_bench;
    localparam logic [3:0] CA = smc_pkg::ADDR_CFG_A;
    localparam logic [3:0] CB = smc_pkg::ADDR_CFG_B;
    localparam logic [3:0] ST = smc_pkg::ADDR_STATUS;
    logic core_clk_i = 1'b0;
    logic srst_i = 1'b1;
    smc_pkg::smc_bus_req_t bus = '0;
    smc_pkg::smc_pins_in_t pins;
    logic req = 0, bit_v = 1, ce = 0, fe = 0, held = 0, pool = 0, rxf = 0, rbe = 0, allow = 0, cd = 0, x;
    logic [31:0] rdata;
    logic rts_n, txd, rxdat, rxen, txen, rs_p, fl_p, irq;
    logic [1:0] eng, ptp;
    logic [2:0] sub;
    int errors = 0, comparisons = 0;
    initial forever #5 core_clk_i = ~core_clk_i;
    smc_modem_ctrl smc_modem_ctrl_inst (.core_clk_i, .srst_i, .bus_i(bus), .rdata_o(rdata), .pins_i(pins),
        .tx_req_i(req), .tx_bit_i(bit_v), .tx_char_end_i(ce), .tx_frame_end_i(fe), .tx_start_held_i(held),
        .tx_pool_released_i(pool), .rx_frame_active_i(rxf), .rx_byte_end_i(rbe), .rts_n_o(rts_n), .txd_o(txd),
        .rx_data_o(rxdat), .rx_enable_o(rxen), .tx_enable_o(txen), .tx_restart_o(rs_p), .tx_flush_o(fl_p),
        .engine_o(eng), .submode_o(sub), .ptp_mode_o(ptp), .irq_pending_o(irq));
    smc_modem_model #(.GRANT_DLY(3)) smc_modem_model_inst (.core_clk_i, .rts_n_i(rts_n), .allow_i(allow),
        .cd_i(cd), .pins_o(pins));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("Comparisons %0d, errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk_i);
        #1;
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge core_clk_i) bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge core_clk_i) bus.wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m = 32'hFFFF_FFFF);
        @(posedge core_clk_i) bus <= '{addr: a, wdata: '0, wr: 1'b0, rd: 1'b1};
        @(posedge core_clk_i) bus.rd <= 1'b0;
        #1 chk(rdata & m, e);
    endtask
    task automatic wait_hi(ref logic s);
        int n = 0;
        while (s !== 1'b1 && n < 50) begin
            @(negedge core_clk_i);
            n++;
        end
        if (s !== 1'b1) begin
            errors++;
            tally_and_finish();
        end
    endtask
    task automatic fend();
        @(posedge core_clk_i) {req, fe} <= 2'b01;
        @(posedge core_clk_i) fe <= 1'b0;
    endtask
    initial begin
        repeat (20) @(posedge core_clk_i);
        srst_i <= 1'b0;
        rd(smc_pkg::ADDR_MASK, smc_pkg::MASK_RST);
        rd(CB, smc_pkg::CFG_B_RST);
        rd(4'h5, 32'h0000_0000);
        chk(rts_n, 1'b1);
        wr(smc_pkg::ADDR_MASK, 32'h0000_0000);
        @(posedge core_clk_i) req <= 1'b1;
        tick(3);
        chk(rts_n, 1'b0);
        chk(txen, 1'b0);
        @(posedge core_clk_i) allow <= 1'b1;
        wait_hi(txen);
        @(posedge core_clk_i) bit_v <= 1'b0;
        tick(2);
        chk(txd, 1'b0);
        wr(ST, 32'h0000_0007);
        @(posedge core_clk_i) allow <= 1'b0;
        tick(8);
        chk(txen, 1'b0);
        chk(txd, 1'b1);
        chk(irq, 1'b1);
        wr(ST, 32'h0000_0007);
        @(posedge core_clk_i) {held, allow} <= 2'b11;
        wait_hi(rs_p);
        wr(ST, 32'h0000_0007);
        fend();
        rd(ST, 32'h0000_0004, 32'h0000_0006);
        chk(rts_n, 1'b1);
        tick(6);
        @(posedge core_clk_i) req <= 1'b1;
        wait_hi(txen);
        @(posedge core_clk_i) {req, held, pool, allow} <= 4'b0010;
        wait_hi(fl_p);
        tick(2);
        chk(rts_n, 1'b1);
        rd(ST, 32'h0000_0002, 32'h0000_0002);
        wr(CA, 32'h0000_0003);
        @(posedge core_clk_i) {req, allow} <= 2'b11;
        wait_hi(txen);
        @(posedge core_clk_i) {bit_v, allow} <= 2'b00;
        tick(8);
        chk(txd, 1'b0);
        @(posedge core_clk_i) ce <= 1'b1;
        @(posedge core_clk_i) {ce, allow} <= 2'b01;
        tick(3);
        chk(txd, 1'b1);
        wait_hi(txen);
        fend();
        wr(CA, 32'h0000_0004);
        wr(CB, 32'h0000_0003);
        @(posedge core_clk_i) rxf <= 1'b1;
        tick(3);
        chk(rts_n, 1'b0);
        wr(CB, 32'h0000_0006);
        tick(3);
        chk(rts_n, 1'b1);
        wr(CA, 32'h0000_0000);
        wr(CB, 32'h0000_0003);
        tick(3);
        chk(rts_n, 1'b1);
        wr(CB, 32'h0000_0004);
        tick(2);
        chk(rts_n, 1'b0);
        wr(CB, 32'h0000_0010);
        tick(6);
        chk(rxdat, 1'b1);
        tick(1);
        chk(rxdat, 1'b1);
        wr(CA, 32'h0000_0040);
        tick(5);
        x = rxdat;
        tick(1);
        chk(rxdat ^ x, 1'b1);
        wr(CA, 32'h0000_0000);
        wr(CB, 32'h0000_0008);
        @(posedge core_clk_i) rbe <= 1'b1;
        @(posedge core_clk_i) rbe <= 1'b0;
        tick(2);
        chk(rxen, 1'b0);
        @(posedge core_clk_i) cd <= 1'b1;
        wait_hi(rxen);
        @(posedge core_clk_i) cd <= 1'b0;
        tick(6);
        chk(rxen, 1'b1);
        @(posedge core_clk_i) rbe <= 1'b1;
        @(posedge core_clk_i) rbe <= 1'b0;
        tick(2);
        chk(rxen, 1'b0);
        wr(CA, 32'h0000_0010);
        tick(3);
        chk(rxen, 1'b1);
        for (int j = 0; j < 4; j++) begin
            if (j != 1) begin
                wr(CA, 32'(j));
                tick(2);
                chk(eng, j[1:0]);
            end
        end
        for (int i = 0; i < 8; i++) begin
            wr(CB, {22'h0, i[1:0], i[2], i[1:0], 5'h0});
            tick(2);
            chk(sub, i[1:0] == 2'd3 ? 3'h4 : (i[1:0] == 2'd2 && !i[2]) ? 3'h3 : {1'b0, i[1:0]});
            chk(ptp, i[1:0]);
        end
        tally_and_finish();
    end
endmodule
